// ===== rtl/atq_pkg.sv
// atq_pkg: constants, register map and carrier types of the acquisition transfer queue
// assumes a single 50 MHz clock and an AXI4-Lite master with 32-bit data
package atq_pkg;
  localparam int unsigned ATQ_DEPTH     = 8;
  localparam int unsigned ATQ_PTR_W     = 3;
  localparam int unsigned ATQ_CNT_W     = 4;
  localparam int unsigned ATQ_SIZE_W    = 24;
  localparam int unsigned ATQ_AVG_N     = 16;
  localparam int unsigned ATQ_AVG_LOG   = 4;
  localparam int unsigned ATQ_SUM_W     = 28;
  localparam int unsigned ATQ_ABORT_DLY = 8;
  // register byte offsets
  localparam logic [7:0] ATQ_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ATQ_STAT_OFS   = 8'h04;
  localparam logic [7:0] ATQ_IRQ_OFS    = 8'h08;
  localparam logic [7:0] ATQ_MASK_OFS   = 8'h0C;
  localparam logic [7:0] ATQ_COUNT_OFS  = 8'h10;
  localparam logic [7:0] ATQ_MAX_OFS    = 8'h14;
  localparam logic [7:0] ATQ_MIN_OFS    = 8'h18;
  localparam logic [7:0] ATQ_AVG_OFS    = 8'h1C;
  localparam logic [7:0] ATQ_LOCK_OFS   = 8'h20;
  // control bits
  localparam int unsigned ATQ_C_RUN     = 0;
  localparam int unsigned ATQ_C_ABORT   = 1;
  localparam int unsigned ATQ_C_DEFER   = 2;
  localparam int unsigned ATQ_C_CYCLE   = 3;
  localparam int unsigned ATQ_C_SEL     = 4;
  // interrupt bits
  localparam int unsigned ATQ_I_DROP    = 0;
  localparam int unsigned ATQ_I_REFUSE  = 1;
  localparam int unsigned ATQ_I_W       = 2;
  // lock word: bits 0..11 general, 12..14 cycling-exempt
  localparam int unsigned ATQ_LOCK_W    = 15;
  localparam logic [14:0] ATQ_EXEMPT    = 15'h7000;
  localparam logic [31:0] ATQ_MIN_RST   = 32'h00FFFFFF;
  typedef struct packed {
    logic                  valid;
    logic [ATQ_SIZE_W-1:0] size;
  } atq_frame_t;
endpackage

// ===== rtl/atq_queue.sv
// atq_queue: frame queue, statistics, abort handshake, setting lock, AXI4-Lite registers
// assumes frame strobes and link handshake on the same clock as the bus
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module atq_queue (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite slave
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // acquisition side
  input  wire atq_pkg::atq_frame_t           acq_frame,
  // link side
  output atq_pkg::atq_frame_t                link_frame,
  input  wire logic                          link_done,
  // status
  output logic                               capture_status_flag,
  output logic                               frame_dropped_event,
  output logic                               transfer_busy,
  output logic                               irq
);
  import atq_pkg::*;

  logic [ATQ_SIZE_W-1:0] mem [ATQ_DEPTH];
  logic [ATQ_PTR_W-1:0]  wr_ptr_r, rd_ptr_r;
  logic [ATQ_CNT_W-1:0]  pending_frame_count;
  logic                  run_r, defer_r, cycle_r, aborting_r, sel_r;
  logic [3:0]            abort_cnt_r;
  logic [ATQ_I_W-1:0]    irq_stat_r, irq_mask_r, irq_set;
  logic [ATQ_LOCK_W-1:0] lock_val_r;
  logic [ATQ_SIZE_W-1:0] largest_sent_frame_size, smallest_sent_frame_size;
  logic [ATQ_SIZE_W-1:0] mean_sent_frame_size;
  logic [ATQ_SIZE_W-1:0] hist_r [ATQ_AVG_N];
  logic [ATQ_AVG_LOG-1:0] hist_ptr_r;
  logic [ATQ_SUM_W-1:0]  sum_r;
  logic                  aw_hold_r, w_hold_r;
  logic [7:0]            aw_addr_r;
  logic [31:0]           w_data_r;
  logic                  do_write, store, drop, sent, locked, refuse;
  logic [ATQ_SIZE_W-1:0] sent_size;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      ATQ_CTRL_OFS:  rd_mux = {27'h0, sel_r, cycle_r, defer_r, 1'b0, run_r};
      ATQ_STAT_OFS:  rd_mux = {31'h0, capture_status_flag};
      ATQ_IRQ_OFS:   rd_mux = {30'h0, irq_stat_r};
      ATQ_MASK_OFS:  rd_mux = {30'h0, irq_mask_r};
      ATQ_COUNT_OFS: rd_mux = {28'h0, pending_frame_count};
      ATQ_MAX_OFS:   rd_mux = {8'h0, largest_sent_frame_size};
      ATQ_MIN_OFS:   rd_mux = {8'h0, smallest_sent_frame_size};
      ATQ_AVG_OFS:   rd_mux = {8'h0, mean_sent_frame_size};
      ATQ_LOCK_OFS:  rd_mux = {17'h0, lock_val_r};
      default:       rd_mux = 32'h0;
    endcase
  endfunction

  // frame goes in only when space remains, out only after link completes
  assign store     = acq_frame.valid && run_r && !pending_frame_count[ATQ_CNT_W-1];
  assign drop      = acq_frame.valid && run_r && pending_frame_count[ATQ_CNT_W-1];
  assign sent      = link_frame.valid && link_done;
  assign sent_size = link_frame.size;
  assign locked    = run_r || transfer_busy;
  assign do_write  = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // write channels captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_r <= s_axi_wdata;
      end
      if (do_write) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign aw_hold_r = !s_axi_awready;
  assign w_hold_r  = !s_axi_wready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_arready <= 1'b1;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux(s_axi_araddr);
      s_axi_arready <= 1'b0;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control register and abort; deferred abort keeps status high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 1'b0;
      defer_r <= 1'b0;
      cycle_r <= 1'b0;
      sel_r <= 1'b0;
      aborting_r <= 1'b0;
      abort_cnt_r <= 4'h0;
    end else begin
      if (do_write && aw_addr_r == ATQ_CTRL_OFS && s_axi_wstrb[0]) begin
        run_r   <= w_data_r[ATQ_C_RUN] && !aborting_r;
        defer_r <= w_data_r[ATQ_C_DEFER];
        cycle_r <= w_data_r[ATQ_C_CYCLE];
        sel_r   <= w_data_r[ATQ_C_SEL];
        if (w_data_r[ATQ_C_ABORT] && run_r) begin
          if (defer_r) begin
            aborting_r  <= 1'b1;
            abort_cnt_r <= 4'(ATQ_ABORT_DLY);
            run_r       <= 1'b1;
          end else begin
            run_r <= 1'b0;
          end
        end
      end else if (aborting_r) begin
        abort_cnt_r <= abort_cnt_r - 4'h1;
        if (abort_cnt_r == 4'h1) begin
          aborting_r <= 1'b0;
          run_r      <= 1'b0;
        end
      end
    end
  end

  // host polls this flag until false before going on
  always_ff @(posedge aclk) begin
    if (!aresetn) capture_status_flag <= 1'b0;
    else capture_status_flag <= run_r;
  end

  // locked settings: writes while busy are refused and flagged; with cycle set, bits 12..14 are still written
  assign refuse = do_write && aw_addr_r == ATQ_LOCK_OFS && locked;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_val_r <= 15'h0;
    end else if (do_write && aw_addr_r == ATQ_LOCK_OFS) begin
      if (!locked) lock_val_r <= w_data_r[ATQ_LOCK_W-1:0];
      else if (cycle_r)
        lock_val_r <= (lock_val_r & ~ATQ_EXEMPT) | (w_data_r[ATQ_LOCK_W-1:0] & ATQ_EXEMPT);
    end
  end

  // queue memory and pointers
  always_ff @(posedge aclk) begin
    if (store) mem[wr_ptr_r] <= acq_frame.size;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      pending_frame_count <= 4'h0;
    end else begin
      if (store) wr_ptr_r <= wr_ptr_r + 3'h1;
      if (sent) rd_ptr_r <= rd_ptr_r + 3'h1;
      pending_frame_count <= pending_frame_count + {3'h0, store} - {3'h0, sent};
    end
  end

  // head of queue offered to the link; held until link_done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_frame <= '0;
      transfer_busy <= 1'b0;
    end else begin
      if (sent || !link_frame.valid) begin
        link_frame.valid <= 1'b0;
        if (!sent && pending_frame_count != 4'h0) begin
          link_frame.valid <= 1'b1;
          link_frame.size  <= mem[rd_ptr_r];
        end
      end
      transfer_busy <= link_frame.valid || pending_frame_count != 4'h0;
    end
  end

  // size statistics
  always_ff @(posedge aclk) begin
    if (!aresetn || (!run_r && !transfer_busy)) begin
      largest_sent_frame_size  <= 24'h0;
      smallest_sent_frame_size <= ATQ_MIN_RST[ATQ_SIZE_W-1:0];
    end else if (sent) begin
      if (sent_size > largest_sent_frame_size) largest_sent_frame_size <= sent_size;
      if (sent_size < smallest_sent_frame_size) smallest_sent_frame_size <= sent_size;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ATQ_AVG_N; i++) hist_r[i] <= 24'h0;
      hist_ptr_r <= 4'h0;
      sum_r <= 28'h0;
      mean_sent_frame_size <= 24'h0;
    end else begin
      if (sent) begin
        hist_r[hist_ptr_r] <= sent_size;
        hist_ptr_r <= hist_ptr_r + 4'h1;
        sum_r <= sum_r + {4'h0, sent_size} - {4'h0, hist_r[hist_ptr_r]};
      end
      mean_sent_frame_size <= sum_r[ATQ_SUM_W-1:ATQ_AVG_LOG];
    end
  end

  // interrupts: set wins over write-one-to-clear
  assign irq_set = {refuse, drop};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
      irq <= 1'b0;
      frame_dropped_event <= 1'b0;
    end else begin
      if (do_write && aw_addr_r == ATQ_IRQ_OFS)
        irq_stat_r <= (irq_stat_r & ~w_data_r[ATQ_I_W-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      if (do_write && aw_addr_r == ATQ_MASK_OFS) irq_mask_r <= w_data_r[ATQ_I_W-1:0];
      irq <= |(irq_stat_r & irq_mask_r);
      frame_dropped_event <= drop;
    end
  end

  drop_only_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_dropped_event |-> $past(pending_frame_count) == 4'(ATQ_DEPTH))
    else $error("frame dropped with space left");
  count_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store && !sent |=> pending_frame_count == $past(pending_frame_count) + 4'h1)
    else $error("pending count did not rise");
  count_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sent && !store |=> pending_frame_count == $past(pending_frame_count) - 4'h1)
    else $error("pending count did not fall");
  sequence abort_req_s;
    do_write && aw_addr_r == ATQ_CTRL_OFS && w_data_r[ATQ_C_ABORT] && run_r && defer_r;
  endsequence
  defer_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_req_s |=> ##1 capture_status_flag [*7] ##[1:4] !capture_status_flag)
    else $error("deferred abort timing wrong");
  fast_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr_r == ATQ_CTRL_OFS && w_data_r[ATQ_C_ABORT] && run_r && !defer_r
    |=> ##1 !capture_status_flag)
    else $error("immediate abort left status set");
  lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    refuse && !cycle_r |=> lock_val_r == $past(lock_val_r))
    else $error("locked setting changed");
  cycle_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
    refuse && cycle_r |=> (lock_val_r & ~ATQ_EXEMPT) == ($past(lock_val_r) & ~ATQ_EXEMPT))
    else $error("cycling mode changed locked field");
  head_offer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pending_frame_count != 4'h0 && !link_frame.valid |=> link_frame.valid)
    else $error("pending frame not offered");
  stats_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sent && (run_r || transfer_busy) |=> largest_sent_frame_size >= $past(sent_size))
    else $error("largest size not tracked");
  mean_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> mean_sent_frame_size == $past(sum_r[ATQ_SUM_W-1:ATQ_AVG_LOG]))
    else $error("mean not sum over sixteen");
endmodule

// ===== sim/atq_host_model.sv
// atq_host_model: host end of the link, takes each offered frame after a short delay
// assumes link_frame holds until link_done; stall freezes the host to let the queue fill
module atq_host_model (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // link
  input  wire atq_pkg::atq_frame_t link_frame,
  output logic                     link_done,
  // bench control
  input  wire logic                stall
);
  timeunit 1ns;
  timeprecision 1ps;
  import atq_pkg::*;
  logic [3:0] wait_r;
  // done is a single pulse; the counter restarts once the offer drops
  always_ff @(posedge aclk) begin
    if (!aresetn || !link_frame.valid || link_done) begin
      wait_r    <= 4'h0;
      link_done <= 1'b0;
    end else if (!stall) begin
      if (wait_r == 4'h2) link_done <= 1'b1;
      else wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ===== sim/atq_queue_tb_top.sv
// atq_queue_tb_top: self-checking bench of the frame transfer queue
// assumes atq_pkg and atq_host_model are compiled first
module atq_queue_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import atq_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stall = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  atq_frame_t  acq_frame = '0;
  atq_frame_t  link_frame;
  logic        link_done, capture_status_flag, frame_dropped_event, transfer_busy, irq;
  int          bad_count = 0, checked = 0, drops = 0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) if (frame_dropped_event === 1'b1) drops++;
  atq_queue i_atq_queue (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acq_frame, .link_frame, .link_done,
    .capture_status_flag, .frame_dropped_event, .transfer_busy, .irq);
  atq_host_model i_atq_host_model (.aclk, .aresetn, .link_frame, .link_done, .stall);
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // handshakes are judged from values seen at the falling edge, which match the next rise
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    logic [1:0] br;
    int n;
    n = 0;
    br = 2'b11;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end while (tb !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    check({31'h0, tb}, 32'h1);
    check({30'h0, br}, 32'h0);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v);
    logic ta, tr;
    logic [1:0] rr;
    int n;
    n = 0;
    rr = 2'b11;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready & s_axi_arvalid;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end while (tr !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    check({31'h0, tr}, 32'h1);
    check({30'h0, rr}, 32'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    axi_read(a, v);
    check(v, e);
  endtask
  task automatic t_reset();
    rd_chk(ATQ_STAT_OFS, 32'h0);
    rd_chk(ATQ_COUNT_OFS, 32'h0);
    rd_chk(ATQ_MIN_OFS, ATQ_MIN_RST);
    rd_chk(ATQ_MAX_OFS, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask
  task automatic t_lock();
    axi_write(ATQ_LOCK_OFS, 32'h5);
    rd_chk(ATQ_LOCK_OFS, 32'h5);
    axi_write(ATQ_CTRL_OFS, 32'h1);
    axi_write(ATQ_LOCK_OFS, 32'h7FFF);
    rd_chk(ATQ_LOCK_OFS, 32'h5);
    rd_chk(ATQ_IRQ_OFS, 32'h2);
    axi_write(ATQ_CTRL_OFS, 32'h9);
    axi_write(ATQ_LOCK_OFS, 32'h7FFF);
    rd_chk(ATQ_LOCK_OFS, 32'h7005);
    axi_write(ATQ_IRQ_OFS, 32'h3);
    axi_write(ATQ_CTRL_OFS, 32'h1);
  endtask
  // host stalled: eight frames fit, the ninth is lost
  task automatic t_fill();
    @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      acq_frame <= '{1'b1, 24'(i + 1)};
      @(posedge aclk);
    end
    acq_frame <= '0;
    tick(3);
    check(32'(drops), 32'h1);
    check({31'h0, link_frame.valid}, 32'h1);
    check({8'h0, link_frame.size}, 32'h1);
    check({31'h0, transfer_busy}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd_chk(ATQ_COUNT_OFS, 32'h8);
    rd_chk(ATQ_IRQ_OFS, 32'h1);
    axi_write(ATQ_MASK_OFS, 32'h1);
    tick(2);
    check({31'h0, irq}, 32'h1);
    axi_write(ATQ_IRQ_OFS, 32'h1);
    tick(2);
    check({31'h0, irq}, 32'h0);
  endtask
  task automatic t_drain();
    int n;
    n = 0;
    stall <= 1'b0;
    while (transfer_busy !== 1'b0 && n < 500) begin
      @(negedge aclk);
      n++;
    end
    check({31'h0, transfer_busy}, 32'h0);
    rd_chk(ATQ_COUNT_OFS, 32'h0);
    rd_chk(ATQ_MAX_OFS, 32'h8);
    rd_chk(ATQ_MIN_OFS, 32'h1);
    rd_chk(ATQ_AVG_OFS, 32'(36 / ATQ_AVG_N));
    axi_write(ATQ_CTRL_OFS, 32'h0);
    rd_chk(ATQ_MAX_OFS, 32'h0);
    rd_chk(ATQ_MIN_OFS, ATQ_MIN_RST);
  endtask
  task automatic t_abort();
    int n;
    n = 0;
    axi_write(ATQ_CTRL_OFS, 32'h1);
    rd_chk(ATQ_STAT_OFS, 32'h1);
    axi_write(ATQ_CTRL_OFS, 32'h2);
    rd_chk(ATQ_STAT_OFS, 32'h0);
    // deferred model: select status, abort, then poll until it falls
    axi_write(ATQ_CTRL_OFS, 32'h15);
    axi_write(ATQ_CTRL_OFS, 32'h16);
    rd_chk(ATQ_STAT_OFS, 32'h1);
    tick(0);
    check({31'h0, capture_status_flag}, 32'h1);
    do begin
      axi_read(ATQ_STAT_OFS, d);
      n++;
    end while (d !== 32'h0 && n < 20);
    check(d, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_lock();
    t_fill();
    t_drain();
    t_abort();
    tally_and_finish();
  end
  // the whole run needs well under a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish();
  end
endmodule
